/* bench/scl_link_props.sv */
/*
 Concurrent checks on the link wires between the host end and the coprocessor end.
 Assumes the core clock and reset of both ends, and HALF_CYC equal to the host's setting.
*/
`timescale 1ns/100ps
`default_nettype none
module scl_link_props
#(
   parameter int HALF_CYC = 20
)(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic sclk,
   input wire logic host_dout,
   input wire logic host_doe,
   input wire logic dev_en,
   input wire logic dev_dout,
   input wire logic dev_soe
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   // ==========================================================
   // Helper logic
   logic [15:0] hi_cnt_r;
   logic [15:0] hi_cnt_nxt;

   // Counts how many core cycles the link clock has stood high.
   always_comb hi_cnt_nxt = sclk ? hi_cnt_r + 16'h0001 : 16'h0000;
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         hi_cnt_r <= 16'h0000;
      else
         hi_cnt_r <= hi_cnt_nxt;
   end

   // ==========================================================
   // Sequences
   sequence s_low_gap;
      !sclk [*8];
   endsequence
   sequence s_rst_rise;
      sclk && $past(sclk) && $rose(host_dout);
   endsequence
   sequence s_rst_end;
      !sclk && !host_doe;
   endsequence

   // ==========================================================
   // Assertions
   chk_high_width: assert property ($fell(sclk) |-> hi_cnt_r == 16'(HALF_CYC) || hi_cnt_r == 16'(2 * HALF_CYC))
      else $error("link clock high phase has the wrong length");
   chk_high_bound: assert property (hi_cnt_r <= 16'(2 * HALF_CYC))
      else $error("link clock held high too long");
   chk_low_gap: assert property ($fell(sclk) |=> s_low_gap)
      else $error("link clock low phase too short");
   chk_data_hold: assert property (sclk && $past(sclk) && host_doe && $past(host_doe) |-> !$fell(host_dout))
      else $error("host data fell while link clock high");
   chk_rst_shape: assert property (s_rst_rise |-> ##HALF_CYC s_rst_end)
      else $error("link reset pulse malformed");
   chk_dir_switch: assert property ($changed(host_doe) |-> !(sclk && $past(sclk)))
      else $error("host line direction changed inside a clock pulse");
   chk_en_lag: assert property ($rose(dev_en) |-> !dev_soe [*3])
      else $error("device drove the line before seeing its enable");
   chk_quiet_off: assert property (!dev_en [*6] |-> !dev_soe)
      else $error("disabled device drives the line");
   chk_read_stable: assert property (dev_soe && $past(dev_soe) && sclk && $past(sclk) && !host_doe |-> $stable(dev_dout))
      else $error("device output bit changed while link clock high");
endmodule
`default_nettype wire

/* bench/testbench.sv */
/*
 Self-checking bench: host and coprocessor ends joined on one shared data line, plus a
 second coprocessor on split lines driven directly by the bench to break the protocol.
 Assumes the package, the link interface and both design ends are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import scl_pkg::*;
   localparam int HALF  = 20;
   localparam int STUCK = 2000;
   typedef struct packed {logic [31:0] x; logic [31:0] y; logic [31:0] d; logic [7:0] s;} scl_row_t;

   logic        clock = 1'b0;
   logic        arst_n;
   logic        dev_select;
   logic        cmd_valid;
   scl_kind_t   cmd_kind;
   logic [7:0]  cmd_byte;
   logic        cmd_ready;
   logic        done;
   logic [7:0]  rx_byte;
   logic [31:0] accum;
   logic        busy;
   logic [31:0] accum2;
   logic        busy2;
   int          n_errors;
   int          num_checks;
   scl_row_t    rows [4] = '{'{32'h12345678, 32'h02345678, 32'h10000000, SIGN_POS},
                            '{32'h00000005, 32'h00000009, 32'hFFFFFFFC, SIGN_NEG},
                            '{32'h80000001, 32'h80000001, 32'h00000000, SIGN_ZERO},
                            '{32'h00000001, 32'hFFFFFFFF, 32'h00000002, SIGN_POS}};

   // ==========================================================
   // Design ends, second device on split lines, checker
   scl_link_if #(.ONE_LINE(1'b1)) lnk ();
   scl_link_if #(.ONE_LINE(1'b0)) lnk2 ();
   scl_host #(.HALF_CYC(16'(HALF))) scl_host_inst (.clock(clock), .arst_n(arst_n), .lnk(lnk),
      .dev_select(dev_select), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_byte(cmd_byte),
      .cmd_ready(cmd_ready), .done(done), .rx_byte(rx_byte));
   scl_device #(.STUCK_LIMIT(32'(STUCK)), .SUB_LIMIT(16'h0032)) scl_device_inst (.clock(clock),
      .arst_n(arst_n), .lnk(lnk), .accum(accum), .busy(busy));
   scl_device #(.STUCK_LIMIT(32'(STUCK)), .SUB_LIMIT(16'h0032)) scl_device_inst2 (.clock(clock),
      .arst_n(arst_n), .lnk(lnk2), .accum(accum2), .busy(busy2));
   scl_link_props #(.HALF_CYC(HALF)) scl_link_props_inst (.clock(clock), .arst_n(arst_n),
      .sclk(lnk.sclk), .host_dout(lnk.host_dout), .host_doe(lnk.host_doe), .dev_en(lnk.dev_en),
      .dev_dout(lnk.dev_dout), .dev_soe(lnk.dev_soe));

   // The core clock runs at 100 MHz.
   always #5 clock = ~clock;

   // ==========================================================
   // Tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   task automatic conclude;
      $display("checks=%0d mismatches=%0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Hands one request to the host end and waits, bounded, for its done pulse.
   task automatic req(input scl_kind_t k, input logic [7:0] b);
      int n;
      @(posedge clock);
      #1;
      cmd_kind = k;
      cmd_byte = b;
      cmd_valid = 1'b1;
      @(posedge clock);
      #1;
      cmd_valid = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 20000)
      begin
         @(posedge clock);
         #1;
         n++;
      end
      if (n >= 20000)
      begin
         n_errors++;
         conclude();
      end
   endtask

   task automatic load(input logic [7:0] op, input logic [31:0] v);
      req(HK_SEND, op);
      for (int i = 3; i >= 0; i--)
         req(HK_SEND, v[8*i+:8]);
   endtask

   task automatic read_acc(input logic [31:0] exp);
      req(HK_SEND, OP_READ_ACCUMULATOR);
      for (int i = 3; i >= 0; i--)
      begin
         req(HK_RECV, 8'h00);
         check(32'(rx_byte), 32'(exp[8*i+:8]));
      end
   endtask

   // Sends one byte on the split lines; glitch pulses the data line while the clock is low.
   task automatic b2(input logic [7:0] b, input logic glitch);
      for (int i = 7; i >= 0; i--)
      begin
         #2 lnk2.host_dout = b[i];
         #6 lnk2.host_dout = b[i] ^ glitch;
         #6 lnk2.host_dout = b[i];
         #10 lnk2.sclk = 1'b1;
         #24 lnk2.sclk = 1'b0;
      end
   endtask

   task automatic load2(input logic [31:0] v, input logic glitch);
      b2(OP_LOADX, glitch);
      for (int i = 3; i >= 0; i--)
         b2(v[8*i+:8], glitch);
      #200;
   endtask

   // The span is about twice the expected run and stays inside the cycle budget.
   initial
   begin
      #900_000;
      n_errors++;
      conclude();
   end

   // ==========================================================
   // Main sequence
   initial
   begin
      {arst_n, dev_select, cmd_valid, cmd_byte, n_errors, num_checks} = '0;
      cmd_kind = HK_SEND;
      {lnk2.sclk, lnk2.host_dout, lnk2.host_doe, lnk2.dev_en} = 4'h0;
      repeat (12) @(posedge clock);
      #1;
      arst_n = 1'b1;
      dev_select = 1'b1;
      lnk2.dev_en = 1'b1;
      lnk2.host_doe = 1'b1;
      repeat (8) @(posedge clock);
      foreach (rows[i])
      begin
         load(OP_LOADX, rows[i].x);
         check(accum, rows[i].x);
         load(OP_LOADY, rows[i].y);
         read_acc(rows[i].x);
         req(HK_SEND, OP_STORE_SCRATCH);
         req(HK_SEND, OP_SUB);
         #20;
         check(32'({busy, lnk.serial_output_pin}), 32'h3);
         req(HK_WAIT, 8'h00);
         check(32'(busy), 32'h0);
         check(accum, rows[i].d);
         req(HK_SEND, OP_DIGIT);
         req(HK_SEND, DIGIT_SIGN_INDEX);
         req(HK_RECV, 8'h00);
         check(32'(rx_byte), 32'(rows[i].s));
         req(HK_SEND, OP_RECALL_SCRATCH);
         read_acc(rows[i].x);
         $display("row %0d finished", i);
      end
      // A link reset in mid-argument drops the partial load.
      load(OP_LOADX, 32'hA5C30F96);
      req(HK_SEND, OP_LOADX);
      req(HK_SEND, 8'h11);
      req(HK_SEND, 8'h22);
      req(HK_CRST, 8'h00);
      read_acc(32'hA5C30F96);
      $display("link reset test finished");
      // A deselected device ignores traffic on the shared lines.
      dev_select = 1'b0;
      repeat (10) @(posedge clock);
      load(OP_LOADX, 32'h0BADF00D);
      dev_select = 1'b1;
      repeat (10) @(posedge clock);
      check(accum, 32'hA5C30F96);
      req(HK_SEND, OP_DIGIT);
      req(HK_SEND, 8'h01);
      req(HK_RECV, 8'h00);
      check(32'(rx_byte), 32'(SIGN_ZERO));
      $display("deselect test finished");
      // Glitches while the clock is low are ignored.
      load2(32'h3C5A9601, 1'b1);
      check(accum2, 32'h3C5A9601);
      // Data rising while the clock is high resets the receiver.
      b2(OP_LOADX, 1'b0);
      b2(8'h77, 1'b0);
      #24 lnk2.host_dout = 1'b0;
      #24 lnk2.sclk = 1'b1;
      #100 lnk2.host_dout = 1'b1;
      #100 lnk2.sclk = 1'b0;
      load2(32'h01234567, 1'b0);
      check(accum2, 32'h01234567);
      // A clock held high too long resets the receiver.
      b2(OP_LOADX, 1'b0);
      #24 lnk2.host_dout = 1'b0;
      #24 lnk2.sclk = 1'b1;
      #(STUCK * 10 + 5000) lnk2.sclk = 1'b0;
      load2(32'hFEDCBA98, 1'b0);
      check(accum2, 32'hFEDCBA98);
      check(32'({busy2, lnk2.dev_soe}), 32'h0);
      $display("split line tests finished");
      // A second reset in mid-run returns both ends to their idle state.
      @(posedge clock);
      #1;
      arst_n = 1'b0;
      #20;
      check(32'({lnk.sclk, lnk.dev_soe, busy, cmd_ready, done}), 32'h2);
      check(accum, 32'h0);
      @(posedge clock);
      #1;
      arst_n = 1'b1;
      repeat (5) @(posedge clock);
      load(OP_LOADX, 32'h13579BDF);
      check(accum, 32'h13579BDF);
      $display("reset test finished");
      conclude();
   end
endmodule
`default_nettype wire

/* src/scl_device.sv */
/*
 Coprocessor end of the link: a receive shifter on the link clock and a
 command engine on the core clock holding X, Y and one scratch register.
 Assumes the host keeps its side of the protocol and a free running core clock.
*/
`timescale 1ns/100ps
`default_nettype none
module scl_device
   import scl_pkg::*;
#(
   parameter logic [31:0] STUCK_LIMIT = 32'(STUCK_CYC),
   parameter logic [15:0] SUB_LIMIT   = 16'(SUB_CYC)
)(
   input  wire logic         clock,
   input  wire logic         arst_n,
   scl_link_if.device        lnk,
   output logic [31:0]       accum,
   output logic              busy
);
   typedef enum logic [2:0] {ST_CMD, ST_ARG, ST_TX, ST_BUSY, ST_READY} scl_dst_t;

   typedef struct packed {
      logic [2:0]  sclk_s;
      logic [2:0]  sdi_s;
      logic [2:0]  en_s;
      logic [2:0]  tog_s;
      logic        sclk_f;
      logic        sdi_f;
      logic        en_f;
      logic        tog_f;
      logic        hold;
      logic        armed;
      logic        soe;
      logic        dout;
      logic        busy;
      logic [31:0] stuck;
      logic [31:0] x;
      logic [31:0] y;
      logic [31:0] s0;
      logic [31:0] sh;
      logic [15:0] wait_cnt;
      logic [5:0]  bits;
      logic [1:0]  nbyte;
      logic [7:0]  opc;
      scl_dst_t    st;
   } scl_core_t;

   typedef struct packed {
      logic [7:0] sh;
      logic [2:0] cnt;
   } scl_lsh_t;

   typedef struct packed {
      logic [7:0] data;
      logic       tog;
   } scl_lbyte_t;

   scl_core_t  r;
   scl_core_t  n;
   scl_lsh_t   lr;
   scl_lsh_t   ln;
   scl_lbyte_t lb;
   scl_lbyte_t lb_n;
   logic       lrst_n;

   // Filtered level: follows the input once the second and third stages agree.
   function automatic logic agree(input logic [2:0] s, input logic f);
      agree = (s[2] == s[1]) ? s[1] : f;
   endfunction

   // ==========================================================
   // Link clock domain
   // The shifter is held in reset by the core during a read or a link reset.
   assign lrst_n = arst_n & ~r.hold;

   // Shift in on every rising link clock; a full byte is handed over by toggle.
   always_comb
   begin
      ln          = lr;
      lb_n        = lb;
      ln.sh       = {lr.sh[6:0], lnk.serial_input_pin};
      ln.cnt      = lr.cnt + 3'h1;
      if (lr.cnt == 3'h7)
      begin
         lb_n.data = {lr.sh[6:0], lnk.serial_input_pin};
         lb_n.tog  = ~lb.tog;
      end
   end

   // Partial bytes die with the hold; the hand-over word keeps its toggle.
   always_ff @(posedge lnk.sclk or negedge lrst_n)
   begin
      if (!lrst_n)
         lr <= '0;
      else
         lr <= ln;
   end

   // The toggle is never reset by the hold, so a reset makes no false byte.
   always_ff @(posedge lnk.sclk or negedge arst_n)
   begin
      if (!arst_n)
         lb <= '0;
      else
         lb <= lb_n;
   end

   // ==========================================================
   // Core clock domain
   // Synchronise the pins, detect events and run the command engine.
   always_comb
   begin
      logic sclk_rise;
      logic sclk_fall;
      logic sdi_rise;
      logic byte_ev;
      logic crst;
      logic [7:0] rxd;
      n           = r;
      n.sclk_s    = {r.sclk_s[1:0], lnk.sclk};
      n.sdi_s     = {r.sdi_s[1:0], lnk.serial_input_pin};
      n.en_s      = {r.en_s[1:0], lnk.dev_en};
      n.tog_s     = {r.tog_s[1:0], lb.tog};
      n.sclk_f    = agree(r.sclk_s, r.sclk_f);
      n.sdi_f     = agree(r.sdi_s, r.sdi_f);
      n.en_f      = agree(r.en_s, r.en_f);
      n.tog_f     = agree(r.tog_s, r.tog_f);
      sclk_rise   = !r.sclk_f && n.sclk_f;
      sclk_fall   = r.sclk_f && !n.sclk_f;
      sdi_rise    = !r.sdi_f && n.sdi_f && r.sclk_f && n.sclk_f;
      byte_ev     = (r.tog_f != n.tog_f);
      rxd         = lb.data;
      // Count the time the clock stays high; one hit when the limit is crossed.
      if (!r.sclk_f)
         n.stuck = '0;
      else if (r.stuck != STUCK_LIMIT)
         n.stuck = r.stuck + 32'h1;
      crst = sdi_rise || (r.stuck == STUCK_LIMIT - 32'h1) || !r.en_f;
      if (crst)
      begin
         n.st    = ST_CMD;
         n.nbyte = '0;
         n.soe   = 1'b0;
         n.armed = 1'b0;
         n.busy  = 1'b0;
      end
      else
      begin
         unique case (r.st)
            ST_CMD:
            begin
               if (byte_ev)
               begin
                  n.opc = rxd;
                  n.armed = 1'b0;
                  case (rxd)
                     OP_LOADX, OP_LOADY:
                     begin
                        n.st    = ST_ARG;
                        n.nbyte = 2'h0;
                     end
                     OP_DIGIT:
                     begin
                        n.st    = ST_ARG;
                        n.nbyte = 2'h3;
                     end
                     OP_READ_ACCUMULATOR:
                     begin
                        n.sh   = r.x;
                        n.bits = 6'(ACC_BITS);
                        n.soe  = 1'b1;
                        n.dout = r.x[31];
                        n.st   = ST_TX;
                     end
                     OP_SUB:
                     begin
                        n.x        = r.x - r.y;
                        n.wait_cnt = SUB_LIMIT;
                        n.busy     = 1'b1;
                        n.st       = ST_BUSY;
                     end
                     OP_STORE_SCRATCH:  n.s0 = r.x;
                     OP_RECALL_SCRATCH: n.x  = r.s0;
                     default:           n.st = ST_CMD;
                  endcase
               end
            end
            ST_ARG:
            begin
               // Gather argument bytes, most significant byte first for a register load.
               if (byte_ev)
               begin
                  n.sh    = {r.sh[23:0], rxd};
                  n.nbyte = r.nbyte + 2'h1;
                  if (r.nbyte == 2'h3)
                  begin
                     n.st = ST_CMD;
                     if (r.opc == OP_LOADX)
                        n.x = {r.sh[23:0], rxd};
                     else if (r.opc == OP_LOADY)
                        n.y = {r.sh[23:0], rxd};
                     else
                     begin
                        // Sign of X for index zero, other indices answer zero.
                        n.sh[31:24] = SIGN_ZERO;
                        if (rxd == DIGIT_SIGN_INDEX && r.x != '0)
                           n.sh[31:24] = r.x[31] ? SIGN_NEG : SIGN_POS;
                        n.sh[23:0] = '0;
                        n.bits     = 6'(BYTE_BITS);
                        n.soe      = 1'b1;
                        n.dout     = n.sh[31];
                        n.st       = ST_TX;
                     end
                  end
               end
            end
            ST_TX:
            begin
               // Next bit goes out on the falling clock so it is stable before the pulse.
               if (sclk_rise)
                  n.armed = 1'b1;
               if (sclk_fall && r.armed)
               begin
                  if (r.bits == 6'h1)
                  begin
                     n.soe = 1'b0;
                     n.st  = ST_CMD;
                  end
                  else
                  begin
                     n.sh   = {r.sh[30:0], 1'b0};
                     n.dout = r.sh[30];
                     n.bits = r.bits - 6'h1;
                  end
               end
            end
            ST_BUSY:
            begin
               // The pull-up holds the output high until the result is ready.
               n.soe = 1'b0;
               if (r.wait_cnt == '0)
               begin
                  n.soe  = 1'b1;
                  n.dout = 1'b0;
                  n.busy = 1'b0;
                  n.st   = ST_READY;
               end
               else
                  n.wait_cnt = r.wait_cnt - 16'h1;
            end
            ST_READY:
            begin
               // Ready low stays until the host has clocked again.
               if (sclk_rise)
                  n.armed = 1'b1;
               if (sclk_fall && r.armed)
               begin
                  n.soe = 1'b0;
                  n.st  = ST_CMD;
               end
            end
            default: n.st = ST_CMD;
         endcase
      end
      n.hold = crst || (n.st == ST_TX);
   end

   // Register the core state.
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         r <= '0;
      else
         r <= n;
   end

   assign lnk.dev_dout = r.dout;
   assign lnk.dev_soe  = r.soe;
   assign accum        = r.x;
   assign busy         = r.busy;
endmodule
`default_nettype wire

/* src/scl_host.sv */
/*
 Host end of the link: makes the link clock by division and runs one request
 at a time (send byte, receive byte, wait ready, link reset).
 Assumes the coprocessor keeps its side of the protocol.
*/
`timescale 1ns/100ps
`default_nettype none
module scl_host
   import scl_pkg::*;
#(
   parameter logic [15:0] HALF_CYC = 16'(SCLK_HALF_CYC)
)(
   input  wire logic         clock,
   input  wire logic         arst_n,
   scl_link_if.host          lnk,
   input  wire logic         dev_select,
   input  wire logic         cmd_valid,
   input  wire scl_kind_t    cmd_kind,
   input  wire logic [7:0]   cmd_byte,
   output logic              cmd_ready,
   output logic              done,
   output logic [7:0]        rx_byte
);
   typedef enum logic [2:0] {H_IDLE, H_LO, H_HI, H_WAIT, H_RA, H_RB} scl_hst_t;

   typedef struct packed {
      logic [2:0]  so_s;
      logic        so_f;
      logic [15:0] cnt;
      logic [2:0]  bitn;
      logic [7:0]  sh;
      logic [7:0]  rx;
      logic        rd;
      logic        sclk;
      logic        dout;
      logic        doe;
      logic        en;
      logic        idle;
      logic        done;
      scl_hst_t    st;
   } scl_host_t;

   scl_host_t r;
   scl_host_t n;

   // ==========================================================
   // Request engine
   // Each clock phase lasts at least HALF_CYC cycles, which keeps the rate below the limit.
   always_comb
   begin
      n        = r;
      n.done   = 1'b0;
      n.en     = dev_select;
      n.so_s   = {r.so_s[1:0], lnk.serial_output_pin};
      n.so_f   = (r.so_s[2] == r.so_s[1]) ? r.so_s[1] : r.so_f;
      unique case (r.st)
         H_IDLE:
         begin
            if (cmd_valid)
            begin
               n.idle = 1'b0;
               n.bitn = '0;
               n.cnt  = HALF_CYC - 16'h1;
               unique case (cmd_kind)
                  HK_SEND:
                  begin
                     n.sh   = cmd_byte;
                     n.doe  = 1'b1;
                     n.dout = cmd_byte[7];
                     n.rd   = 1'b0;
                     n.st   = H_LO;
                  end
                  HK_RECV:
                  begin
                     n.doe = 1'b0;
                     n.rd  = 1'b1;
                     n.st  = H_LO;
                  end
                  HK_WAIT:
                  begin
                     n.doe = 1'b0;
                     n.st  = H_WAIT;
                  end
                  HK_CRST:
                  begin
                     n.doe  = 1'b1;
                     n.dout = 1'b0;
                     n.sclk = 1'b1;
                     n.st   = H_RA;
                  end
               endcase
            end
         end
         H_LO:
         begin
            // Data is stable here; a read samples before raising the clock.
            if (r.cnt == '0)
            begin
               n.cnt  = HALF_CYC - 16'h1;
               n.sclk = 1'b1;
               n.st   = H_HI;
               if (r.rd)
                  n.sh = {r.sh[6:0], r.so_f};
            end
            else
               n.cnt = r.cnt - 16'h1;
         end
         H_HI:
         begin
            if (r.cnt == '0)
            begin
               n.sclk = 1'b0;
               n.cnt  = HALF_CYC - 16'h1;
               if (r.bitn == 3'h7)
               begin
                  n.st   = H_IDLE;
                  n.idle = 1'b1;
                  n.done = 1'b1;
                  if (r.rd)
                     n.rx = r.sh;
               end
               else
               begin
                  n.bitn = r.bitn + 3'h1;
                  n.st   = H_LO;
                  if (!r.rd)
                  begin
                     n.sh   = {r.sh[6:0], 1'b0};
                     n.dout = r.sh[6];
                  end
               end
            end
            else
               n.cnt = r.cnt - 16'h1;
         end
         H_WAIT:
         begin
            // No clock while the line is high.
            if (!r.so_f)
            begin
               n.st   = H_IDLE;
               n.idle = 1'b1;
               n.done = 1'b1;
            end
         end
         H_RA:
         begin
            // Raise data while the clock is high to reset the link.
            if (r.cnt == '0)
            begin
               n.dout = 1'b1;
               n.cnt  = HALF_CYC - 16'h1;
               n.st   = H_RB;
            end
            else
               n.cnt = r.cnt - 16'h1;
         end
         H_RB:
         begin
            if (r.cnt == '0)
            begin
               n.sclk = 1'b0;
               n.doe  = 1'b0;
               n.st   = H_IDLE;
               n.idle = 1'b1;
               n.done = 1'b1;
            end
            else
               n.cnt = r.cnt - 16'h1;
         end
         default: n.st = H_IDLE;
      endcase
   end

   // Register the host state; it comes out of reset idle with the clock low.
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         r      <= '0;
         r.idle <= 1'b1;
         r.so_s <= 3'h7;
         r.so_f <= 1'b1;
      end
      else
         r <= n;
   end

   assign lnk.sclk      = r.sclk;
   assign lnk.host_dout = r.dout;
   assign lnk.host_doe  = r.doe;
   assign lnk.dev_en    = r.en;
   assign cmd_ready     = r.idle;
   assign done          = r.done;
   assign rx_byte       = r.rx;
endmodule
`default_nettype wire

/* src/scl_link_if.sv */
/*
 The link wires between host and coprocessor, with one modport per end.
 Assumes a pull-up on the output line; ONE_LINE feeds the output pin to the input pin while the host does not drive.
*/
`timescale 1ns/100ps
`default_nettype none
interface scl_link_if #(parameter bit ONE_LINE = 1'b1);
   logic sclk;
   logic host_dout;
   logic host_doe;
   logic dev_en;
   logic dev_dout;
   logic dev_soe;
   logic serial_input_pin;
   logic serial_output_pin;

   // ==========================================================
   // Wire resolution: pull-up on the output pin, host wins on a shared line.
   assign serial_output_pin = dev_soe ? dev_dout : 1'b1;
   assign serial_input_pin  = ONE_LINE ? (host_doe ? host_dout : serial_output_pin) : host_dout;

   modport host (output sclk, output host_dout, output host_doe, output dev_en, input serial_output_pin);
   modport device (input sclk, input serial_input_pin, input dev_en, output dev_dout, output dev_soe);
endinterface
`default_nettype wire

/* src/scl_pkg.sv */
/*
 Shared constants and types of the serial coprocessor link: timing counts,
 opcodes, answer codes and host request kinds.
 Assumes a 100 MHz core clock on both ends.
*/
package scl_pkg;
   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int DEV_CLK_MHZ   = 20;   // Device clock at which the link rate limit holds.
   localparam int SCLK_MAX_KHZ  = 100;
   // Half period of the host clock, one cycle more so the rate stays below the limit.
   localparam int SCLK_HALF_CYC = (1_000_000 / SCLK_MAX_KHZ) / (2 * CLK_PERIOD_NS) + 1;
   localparam int STUCK_TIME_MS = 2000; // Two seconds of clock high.
   localparam int STUCK_CYC     = STUCK_TIME_MS * 1_000_000 / CLK_PERIOD_NS;
   localparam int SUB_TIME_US   = 110;
   localparam int SUB_CYC       = SUB_TIME_US * 1000 / CLK_PERIOD_NS;

   // ==========================================================
   // Framing
   localparam int BYTE_BITS = 8;
   localparam int ACC_BITS  = 32;

   // ==========================================================
   // Opcodes
   localparam logic [7:0] OP_LOADX             = 8'h01;
   localparam logic [7:0] OP_LOADY             = 8'h02;
   localparam logic [7:0] OP_READ_ACCUMULATOR  = 8'h03;
   localparam logic [7:0] OP_SUB               = 8'h04;
   localparam logic [7:0] OP_STORE_SCRATCH     = 8'h05;
   localparam logic [7:0] OP_RECALL_SCRATCH    = 8'h06;
   localparam logic [7:0] OP_DIGIT             = 8'h07;

   // ==========================================================
   // Sign answers of digit index zero
   localparam logic [7:0] DIGIT_SIGN_INDEX = 8'h00;
   localparam logic [7:0] SIGN_POS         = 8'h01;
   localparam logic [7:0] SIGN_NEG         = 8'hFF;
   localparam logic [7:0] SIGN_ZERO        = 8'h00;

   // ==========================================================
   // Host request kinds
   typedef enum logic [1:0] {HK_SEND, HK_RECV, HK_WAIT, HK_CRST} scl_kind_t;
endpackage
